// >>> ptd_pkg.sv
// Constants and types shared by the passive target discovery block.
package ptd_pkg;
  localparam logic [7:0] PTD_CMD_CODE = 8'h4A;
  localparam logic [7:0] PTD_RESP_CODE = 8'h4B;
  localparam logic [7:0] PTD_SEL_A = 8'h00;
  localparam logic [7:0] PTD_SEL_POLL_LO = 8'h01;
  localparam logic [7:0] PTD_SEL_POLL_HI = 8'h02;
  localparam logic [7:0] PTD_SEL_B106 = 8'h03;
  localparam logic [7:0] PTD_SEL_TAG = 8'h04;
  localparam logic [7:0] PTD_SEL_RSVD = 8'h05;
  localparam logic [7:0] PTD_SEL_B212 = 8'h06;
  localparam logic [7:0] PTD_SEL_B847 = 8'h08;
  localparam logic [7:0] PTD_LIMIT_MAX = 8'h01;
  localparam logic [7:0] PTD_TARGET_NUM = 8'h01;
  localparam logic [7:0] PTD_CASCADE_TAG = 8'h88;
  localparam logic [7:0] PTD_POLL_RC = 8'h01;
  localparam logic [7:0] PTD_ERR_CODE = 8'h27;
  localparam int PTD_ISO4_BIT = 5;
  localparam logic [4:0] PTD_HDR_BYTES = 5'h03;
  localparam logic [4:0] PTD_MAX_CMD = 5'h13;
  localparam logic [4:0] PTD_UID_L1 = 5'h04;
  localparam logic [4:0] PTD_UID_L2 = 5'h08;
  localparam logic [4:0] PTD_UID_L3 = 5'h0C;
  localparam logic [4:0] PTD_B_MAX = 5'h02;
  localparam logic [4:0] PTD_POLL_LEN = 5'h05;
  localparam int PTD_TSN_IDX = 4;
  localparam logic [7:0] PTD_POLL_RX_SHORT = 8'h11;
  localparam logic [7:0] PTD_POLL_RX_LONG = 8'h13;
  localparam logic [7:0] PTD_CT_POS1 = 8'h01;
  localparam logic [7:0] PTD_CT_POS2 = 8'h05;
  localparam int PTD_BUF_START = 3;
  localparam int PTD_CLK_MHZ = 125;
  localparam int PTD_PROBE_NS = 5000000;
  localparam int PTD_POLL_BASE_NS = 2420000;
  localparam int PTD_POLL_SLOT_NS = 1210000;
  localparam int PTD_PROBE_CYC = (PTD_PROBE_NS * PTD_CLK_MHZ + 999) / 1000;
  localparam int PTD_POLL_BASE_CYC = (PTD_POLL_BASE_NS * PTD_CLK_MHZ + 999) / 1000;
  localparam int PTD_POLL_SLOT_CYC = (PTD_POLL_SLOT_NS * PTD_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] PTD_REG_STATUS = 8'h00;
  localparam logic [7:0] PTD_REG_RETRY = 8'h04;
  localparam logic [7:0] PTD_REG_ANALOG = 8'h08;
  localparam logic [7:0] PTD_RETRY_RST = 8'h02;
  localparam logic [31:0] PTD_ANALOG_RST = 32'h00000000;
  typedef enum logic [3:0] {
    OP_NONE, OP_SENSE, OP_WAKE_ALL, OP_SELECT, OP_RATS, OP_REQB, OP_SLOT_ANTI,
    OP_PROB_ANTI, OP_ATTRIB, OP_POLL, OP_TAG_PROBE, OP_TAG_READ_ID
  } ptd_op_type;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CHECK, ST_TG, ST_GO, ST_WAIT, ST_LEN, ST_NEXT, ST_FIN, ST_OUT
  } ptd_state_type;
endpackage

// >>> ptd_timer.sv
// Down-counting timeout timer with a one-cycle expiry pulse.
`timescale 1ns/10ps
module ptd_timer #(
  parameter int TW = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [TW-1:0] value_i,
  input wire logic stop_i,
  output logic expired_o
);
  logic [TW-1:0] cnt_reg;
  logic run_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      expired_o <= 1'b0;
    end else if (load_i) begin
      cnt_reg <= value_i;
      run_reg <= 1'b1;
      expired_o <= 1'b0;
    end else if (stop_i || !run_reg) begin
      run_reg <= 1'b0;
      expired_o <= 1'b0;
    end else if (cnt_reg <= TW'(1)) begin
      run_reg <= 1'b0;
      expired_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - TW'(1);
      expired_o <= 1'b0;
    end
  end
endmodule

// >>> ptd_discovery.sv
// Passive target discovery command interpreter with a Wishbone register slave.
`timescale 1ns/10ps
module ptd_discovery import ptd_pkg::*; #(
  parameter int BUF_DEPTH = 64,
  parameter int PROBE_CYC = PTD_PROBE_CYC,
  parameter int POLL_BASE_CYC = PTD_POLL_BASE_CYC,
  parameter int POLL_SLOT_CYC = PTD_POLL_SLOT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_last_i,
  output logic cmd_ready_o,
  output logic resp_valid_o,
  output logic [7:0] resp_data_o,
  output logic resp_last_o,
  input wire logic resp_ready_i,
  output logic rf_go_o,
  output logic rf_abort_o,
  output ptd_op_type rf_op_o,
  output logic [1:0] rf_rate_o,
  output logic [31:0] rf_analog_o,
  input wire logic [3:0] rf_param_idx_i,
  output logic [7:0] rf_param_o,
  output logic [4:0] rf_param_cnt_o,
  input wire logic rf_rx_valid_i,
  input wire logic [7:0] rf_rx_data_i,
  input wire logic rf_collision_i,
  input wire logic rf_done_i,
  input wire logic rf_ok_i,
  output logic target_active_o
);
  localparam int BW = $clog2(BUF_DEPTH);
  localparam int TW = 24;

  ptd_state_type state;
  ptd_op_type op_next;
  ptd_op_type op_first;
  logic [7:0] buf_reg [BUF_DEPTH];
  logic [7:0] param_reg [16];
  logic [4:0] cnt_reg, pcnt_reg;
  logic code_bad_reg, ovf_reg, err_reg, iso_reg, poll_bad_reg, found_reg;
  logic [7:0] limit_reg, sel_reg, retry_reg, retry_lim_reg, rx_cnt_reg;
  logic [BW-1:0] ptr_reg, slot_reg, out_idx_reg, out_len_reg;
  logic sel_a, sel_poll, sel_b, sel_tag, tsn_ok, syn_err, prob;
  logic store, ok_done, fail, give_up, wr_en, tmr_exp;
  logic [BW-1:0] wr_idx;
  logic [7:0] wr_data, tsn;
  logic [TW-1:0] tmr_val;
  logic cmd_take;

  assign cmd_take = cmd_valid_i && cmd_ready_o;
  assign tsn = param_reg[PTD_TSN_IDX];
  assign sel_a = sel_reg == PTD_SEL_A;
  assign sel_poll = sel_reg == PTD_SEL_POLL_LO || sel_reg == PTD_SEL_POLL_HI;
  assign sel_b = sel_reg == PTD_SEL_B106 ||
                 (sel_reg >= PTD_SEL_B212 && sel_reg <= PTD_SEL_B847);
  assign sel_tag = sel_reg == PTD_SEL_TAG;
  assign tsn_ok = tsn == 8'h00 || tsn == 8'h01 || tsn == 8'h03 ||
                  tsn == 8'h07 || tsn == 8'h0F;
  assign prob = pcnt_reg == PTD_B_MAX && param_reg[1][0];
  assign syn_err = code_bad_reg || ovf_reg || cnt_reg < PTD_HDR_BYTES ||
    limit_reg != PTD_LIMIT_MAX || !(sel_a || sel_poll || sel_b || sel_tag) ||
    (sel_a && pcnt_reg != 5'h00 && pcnt_reg != PTD_UID_L1 &&
     pcnt_reg != PTD_UID_L2 && pcnt_reg != PTD_UID_L3) ||
    (sel_b && (pcnt_reg == 5'h00 || pcnt_reg > PTD_B_MAX)) ||
    (sel_poll && (pcnt_reg != PTD_POLL_LEN || !tsn_ok));
  assign op_first = sel_a ? (pcnt_reg != 5'h00 ? OP_WAKE_ALL : OP_SENSE) :
                    sel_b ? OP_REQB : sel_poll ? OP_POLL : OP_TAG_PROBE;
  assign ok_done = rf_done_i && rf_ok_i && !(rf_op_o == OP_POLL && (poll_bad_reg ||
    (rx_cnt_reg != PTD_POLL_RX_SHORT && rx_cnt_reg != PTD_POLL_RX_LONG)));
  assign fail = state == ST_WAIT && ((rf_done_i && !ok_done) || (!rf_done_i && tmr_exp));
  assign give_up = retry_reg + 8'h01 >= retry_lim_reg;
  assign tmr_val = rf_op_o == OP_POLL ?
    TW'(POLL_BASE_CYC + (int'(tsn) + 1) * POLL_SLOT_CYC) : TW'(PROBE_CYC);

  always_comb begin
    case (rf_op_o)
      OP_SENSE, OP_WAKE_ALL: op_next = OP_SELECT;
      OP_SELECT: op_next = iso_reg ? OP_RATS : OP_NONE;
      OP_REQB: op_next = prob ? OP_PROB_ANTI : OP_SLOT_ANTI;
      OP_PROB_ANTI, OP_SLOT_ANTI: op_next = OP_ATTRIB;
      OP_TAG_PROBE: op_next = OP_TAG_READ_ID;
      default: op_next = OP_NONE;
    endcase
  end

  always_comb begin
    store = 1'b0;
    if (state == ST_WAIT && rf_rx_valid_i) begin
      case (rf_op_o)
        OP_PROB_ANTI, OP_SLOT_ANTI: store = 1'b0;
        OP_SELECT: store = !((rx_cnt_reg == PTD_CT_POS1 || rx_cnt_reg == PTD_CT_POS2) &&
                             rf_rx_data_i == PTD_CASCADE_TAG);
        default: store = 1'b1;
      endcase
    end
  end

  always_comb begin
    wr_en = 1'b0;
    wr_idx = ptr_reg;
    wr_data = rf_rx_data_i;
    case (state)
      ST_CHECK: begin
        wr_en = 1'b1;
        wr_idx = '0;
        wr_data = syn_err ? PTD_ERR_CODE : PTD_RESP_CODE;
      end
      ST_TG: begin
        wr_en = 1'b1;
        wr_idx = BW'(2);
        wr_data = PTD_TARGET_NUM;
      end
      ST_WAIT: begin
        wr_en = store;
        if ((rf_op_o == OP_SENSE || rf_op_o == OP_WAKE_ALL) && rf_collision_i) begin
          wr_data = 8'h00;
        end
      end
      ST_LEN: begin
        wr_en = 1'b1;
        wr_idx = slot_reg;
        wr_data = 8'(ptr_reg - slot_reg - BW'(1)) +
                  (rf_op_o == OP_POLL ? 8'h01 : 8'h00);
      end
      ST_FIN: begin
        wr_en = 1'b1;
        wr_idx = BW'(1);
        wr_data = {7'h00, found_reg};
      end
      default: wr_en = 1'b0;
    endcase
  end

  for (genvar g = 0; g < BUF_DEPTH; g++) begin : g_buf
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        buf_reg[g] <= 8'h00;
      end else if (wr_en && wr_idx == BW'(g)) begin
        buf_reg[g] <= wr_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 5'h00;
      pcnt_reg <= 5'h00;
      code_bad_reg <= 1'b0;
      ovf_reg <= 1'b0;
      limit_reg <= 8'h00;
      sel_reg <= 8'h00;
      cmd_ready_o <= 1'b0;
      for (int i = 0; i < 16; i++) param_reg[i] <= 8'h00;
    end else begin
      cmd_ready_o <= state == ST_IDLE && !(cmd_take && cmd_last_i);
      if (state == ST_OUT) begin
        cnt_reg <= 5'h00;
        pcnt_reg <= 5'h00;
        code_bad_reg <= 1'b0;
        ovf_reg <= 1'b0;
      end else if (cmd_take) begin
        if (cnt_reg == PTD_MAX_CMD) begin
          ovf_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 5'h01;
        end
        if (cnt_reg == 5'h00) code_bad_reg <= cmd_data_i != PTD_CMD_CODE;
        if (cnt_reg == 5'h01) limit_reg <= cmd_data_i;
        if (cnt_reg == 5'h02) sel_reg <= cmd_data_i;
        if (cnt_reg >= PTD_HDR_BYTES && cnt_reg < PTD_MAX_CMD) begin
          param_reg[4'(cnt_reg - PTD_HDR_BYTES)] <= cmd_data_i;
          pcnt_reg <= pcnt_reg + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      rf_op_o <= OP_NONE;
      retry_reg <= 8'h00;
      found_reg <= 1'b0;
      err_reg <= 1'b0;
      target_active_o <= 1'b0;
      out_len_reg <= '0;
      rf_go_o <= 1'b0;
      rf_abort_o <= 1'b0;
    end else begin
      rf_go_o <= state == ST_GO;
      rf_abort_o <= fail && !rf_done_i;
      case (state)
        ST_IDLE: if (cmd_take && cmd_last_i) state <= ST_CHECK;
        ST_CHECK: begin
          err_reg <= syn_err;
          found_reg <= 1'b0;
          out_len_reg <= BW'(1);
          state <= syn_err ? ST_OUT : ST_TG;
        end
        ST_TG: begin
          target_active_o <= 1'b0;
          rf_op_o <= op_first;
          retry_reg <= 8'h00;
          state <= ST_GO;
        end
        ST_GO: state <= ST_WAIT;
        ST_WAIT: begin
          if (ok_done) begin
            state <= (rf_op_o == OP_ATTRIB || rf_op_o == OP_POLL ||
                      rf_op_o == OP_SELECT) ? ST_LEN : ST_NEXT;
          end else if (fail && give_up) begin
            state <= ST_FIN;
          end else if (fail) begin
            retry_reg <= retry_reg + 8'h01;
            rf_op_o <= op_first;
            state <= ST_GO;
          end
        end
        ST_LEN: state <= ST_NEXT;
        ST_NEXT: begin
          rf_op_o <= op_next;
          if (op_next == OP_NONE) begin
            found_reg <= 1'b1;
            state <= ST_FIN;
          end else begin
            state <= ST_GO;
          end
        end
        ST_FIN: begin
          target_active_o <= found_reg;
          out_len_reg <= found_reg ? ptr_reg : BW'(2);
          state <= ST_OUT;
        end
        ST_OUT: if (out_idx_reg == out_len_reg && (!resp_valid_o || resp_ready_i)) begin
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_reg <= BW'(PTD_BUF_START);
      slot_reg <= '0;
      rx_cnt_reg <= 8'h00;
      iso_reg <= 1'b0;
      poll_bad_reg <= 1'b0;
    end else if (state == ST_TG || fail) begin
      ptr_reg <= BW'(PTD_BUF_START);
    end else if (state == ST_GO) begin
      rx_cnt_reg <= 8'h00;
      poll_bad_reg <= 1'b0;
      if (rf_op_o == OP_ATTRIB || rf_op_o == OP_POLL) begin
        slot_reg <= ptr_reg;
        ptr_reg <= ptr_reg + BW'(1);
      end
    end else if (state == ST_WAIT && rf_rx_valid_i) begin
      if (rx_cnt_reg != 8'hFF) rx_cnt_reg <= rx_cnt_reg + 8'h01;
      if (rf_op_o == OP_POLL && rx_cnt_reg == 8'h00) begin
        poll_bad_reg <= rf_rx_data_i != PTD_POLL_RC;
      end
      if (rf_op_o == OP_SELECT && rx_cnt_reg == 8'h00) begin
        iso_reg <= rf_rx_data_i[PTD_ISO4_BIT];
        slot_reg <= ptr_reg + BW'(1);
        ptr_reg <= ptr_reg + BW'(2);
      end else if (store && ptr_reg != BW'(BUF_DEPTH - 1)) begin
        ptr_reg <= ptr_reg + BW'(1);
      end
    end
  end

  ptd_timer #(
    .TW(TW)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(state == ST_GO),
    .value_i(tmr_val),
    .stop_i(state == ST_WAIT && rf_done_i),
    .expired_o(tmr_exp)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rf_rate_o <= 2'h0;
      rf_param_o <= 8'h00;
      rf_param_cnt_o <= 5'h00;
    end else begin
      rf_param_o <= param_reg[rf_param_idx_i];
      rf_param_cnt_o <= sel_tag ? 5'h00 : pcnt_reg;
      if (state == ST_TG) begin
        rf_rate_o <= sel_b && sel_reg != PTD_SEL_B106 ? 2'(sel_reg - PTD_SEL_RSVD) :
                     sel_poll ? sel_reg[1:0] : 2'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_idx_reg <= '0;
      resp_valid_o <= 1'b0;
      resp_data_o <= 8'h00;
      resp_last_o <= 1'b0;
    end else if (state != ST_OUT) begin
      out_idx_reg <= '0;
    end else if (!resp_valid_o || resp_ready_i) begin
      if (out_idx_reg != out_len_reg) begin
        resp_valid_o <= 1'b1;
        resp_data_o <= buf_reg[out_idx_reg];
        resp_last_o <= out_idx_reg == out_len_reg - BW'(1);
        out_idx_reg <= out_idx_reg + BW'(1);
      end else begin
        resp_valid_o <= 1'b0;
        resp_last_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      retry_lim_reg <= PTD_RETRY_RST;
      rf_analog_o <= PTD_ANALOG_RST;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= 32'h00000000;
        if (wb_we_i && wb_adr_i == PTD_REG_RETRY && wb_sel_i[0]) begin
          retry_lim_reg <= wb_dat_i[7:0];
        end
        for (int b = 0; b < 4; b++) begin
          if (wb_we_i && wb_adr_i == PTD_REG_ANALOG && wb_sel_i[b]) begin
            rf_analog_o[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
        if (!wb_we_i && wb_adr_i == PTD_REG_STATUS) begin
          wb_dat_o <= {28'h0000000, state != ST_IDLE, err_reg, target_active_o, found_reg};
        end
        if (!wb_we_i && wb_adr_i == PTD_REG_RETRY) wb_dat_o <= {24'h000000, retry_lim_reg};
        if (!wb_we_i && wb_adr_i == PTD_REG_ANALOG) wb_dat_o <= rf_analog_o;
      end
    end
  end

  a_limit_reject: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_CHECK && limit_reg != PTD_LIMIT_MAX |=> state == ST_OUT ##1 buf_reg[0] == PTD_ERR_CODE)
    else $error("bad target limit not rejected");
  a_bad_selector: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_CHECK && sel_reg == PTD_SEL_RSVD |=> out_len_reg == BW'(1) && err_reg)
    else $error("reserved selector not rejected");
  a_tsn_reject: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_CHECK && sel_poll && !tsn_ok |=> buf_reg[0] == PTD_ERR_CODE)
    else $error("illegal time slot accepted");
  a_afi_missing: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_CHECK && sel_b && pcnt_reg == 5'h00 |=> err_reg)
    else $error("missing family byte accepted");
  a_resp_header: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_FIN |=> buf_reg[0] == PTD_RESP_CODE && buf_reg[1] <= 8'h01)
    else $error("bad response header");
  a_target_num: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_TG |=> buf_reg[2] == PTD_TARGET_NUM)
    else $error("logical number not one");
  a_collision_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_WAIT && rf_rx_valid_i && rf_collision_i && rf_op_o == OP_SENSE
    |=> buf_reg[$past(ptr_reg)] == 8'h00)
    else $error("collided sense byte not zeroed");
  a_ct_strip: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_WAIT && rf_op_o == OP_SELECT && rf_rx_valid_i && rx_cnt_reg == PTD_CT_POS1 &&
    rf_rx_data_i == PTD_CASCADE_TAG |=> $stable(ptr_reg))
    else $error("cascade tag stored");
  a_rate_847: assert property (@(posedge clk_i) disable iff (rst_i)
    rf_go_o && rf_op_o == OP_ATTRIB && sel_reg == PTD_SEL_B847 |-> rf_rate_o == 2'h3)
    else $error("type B rate not negotiated");
  a_rats_iso: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_NEXT && rf_op_o == OP_SELECT && iso_reg |=> rf_op_o == OP_RATS ##1 rf_go_o)
    else $error("RATS not sent to compliant target");
  a_give_up: assert property (@(posedge clk_i) disable iff (rst_i)
    fail && give_up |=> state == ST_FIN && !found_reg ##1 out_len_reg == BW'(2))
    else $error("exhausted retries not reported as zero");
  a_keep_active: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_FIN && found_reg |=> target_active_o [*2])
    else $error("found target not left active");
  a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");
endmodule

// >>> ptd_rf_model.sv
// Behavioural RF engine that answers the operations of the discovery block.
`timescale 1ns/10ps
module ptd_rf_model import ptd_pkg::*; (
  input wire logic clk_i,
  input wire logic go_i,
  input wire ptd_op_type op_i,
  input wire logic silent_i,
  input wire logic [31:0] id_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic done_o,
  output logic ok_o
);
  ptd_op_type op_reg;
  int n;
  function automatic int rx_len(input ptd_op_type op);
    case (op)
      OP_POLL: return 17;
      OP_SENSE, OP_WAKE_ALL: return 2;
      OP_SELECT: return 9;
      OP_RATS: return 3;
      OP_REQB: return 12;
      OP_TAG_PROBE: return 2;
      OP_TAG_READ_ID: return 4;
      OP_ATTRIB: return 1;
      default: return 0;
    endcase
  endfunction
  function automatic logic [7:0] rx_byte(input ptd_op_type op, input int i, input logic [31:0] id);
    case (op)
      OP_POLL: return (i == 0) ? PTD_POLL_RC : 8'(8'h20 + i);
      OP_REQB: return 8'(8'h50 + i);
      OP_TAG_PROBE, OP_SENSE, OP_WAKE_ALL: return (i == 0) ? 8'h04 : 8'h00;
      OP_SELECT: return (i == 0) ? 8'h20 : (i == 1) ? PTD_CASCADE_TAG : 8'(8'h30 + i);
      OP_RATS: return (i == 0) ? 8'h03 : 8'(8'h40 + i);
      OP_TAG_READ_ID: return id[31-8*i -: 8];
      default: return 8'h01;
    endcase
  endfunction
  // A silent field never answers, so the block has to time out and retry.
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h5A;
    done_o = 1'b0;
    ok_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i && !silent_i) begin
        op_reg = op_i;
        n = rx_len(op_reg);
        @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
          rx_valid_o <= 1'b1;
          rx_data_o <= rx_byte(op_reg, i, id_i);
          @(posedge clk_i);
        end
        rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
        done_o <= 1'b1;
        ok_o <= 1'b1;
        @(posedge clk_i);
        done_o <= 1'b0;
        ok_o <= 1'b0;
      end
    end
  end
endmodule

// >>> ptd_discovery_bench.sv
// Self-checking bench for the passive target discovery block.
`timescale 1ns/10ps
module ptd_discovery_bench import ptd_pkg::*; ();
  typedef logic [7:0] ptd_bq_type [$];
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rf_analog_o, id = 32'h0, seed = 32'h08F5;
  logic cmd_valid_i = 1'b0, cmd_last_i = 1'b0, cmd_ready_o, resp_ready_i = 1'b0;
  logic [7:0] cmd_data_i = 8'h00, resp_data_o, rf_rx_data_i, rf_param_o;
  logic resp_valid_o, resp_last_o, rf_go_o, rf_rx_valid_i, rf_done_i, rf_ok_i;
  logic target_active_o, silent = 1'b0, rf_abort_o, collide = 1'b0;
  logic [1:0] rf_rate_o, last_rate, cnt = 2'h0;
  logic [4:0] rf_param_cnt_o, last_pcnt;
  logic [3:0] wb_sel_i = 4'hF, sel = 4'hF, rf_param_idx_i = 4'h4;
  ptd_op_type rf_op_o;
  ptd_op_type op_q [$];
  logic [8:0] exp_q [$];
  int bad_count = 0;
  int num_checks = 0;
  int aborts = 0;
  always #4 clk_i = ~clk_i;
  ptd_discovery #(.PROBE_CYC(20), .POLL_BASE_CYC(30), .POLL_SLOT_CYC(10)) u_ptd_discovery (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .cmd_valid_i, .cmd_data_i, .cmd_last_i, .cmd_ready_o,
    .resp_valid_o, .resp_data_o, .resp_last_o, .resp_ready_i, .rf_go_o, .rf_abort_o,
    .rf_op_o, .rf_rate_o, .rf_analog_o, .rf_param_idx_i, .rf_param_o,
    .rf_param_cnt_o, .rf_rx_valid_i, .rf_rx_data_i, .rf_collision_i(collide), .rf_done_i,
    .rf_ok_i, .target_active_o);
  ptd_rf_model u_ptd_rf_model (.clk_i, .go_i(rf_go_o), .op_i(rf_op_o), .silent_i(silent),
    .id_i(id), .rx_valid_o(rf_rx_valid_i), .rx_data_o(rf_rx_data_i), .done_o(rf_done_i),
    .ok_o(rf_ok_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= sel;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic run(input ptd_bq_type cmd, input ptd_bq_type rsp);
    foreach (rsp[i]) exp_q.push_back({i == rsp.size() - 1, rsp[i]});
    foreach (cmd[i]) begin
      cmd_valid_i <= 1'b1;
      cmd_data_i <= cmd[i];
      cmd_last_i <= (i == cmd.size() - 1);
      do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
    end
    cmd_valid_i <= 1'b0;
    cmd_last_i <= 1'b0;
    while (exp_q.size() != 0) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
  endtask
  // The response sink stalls one cycle in four.
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
    resp_ready_i <= cnt[0] | cnt[1];
    if (rf_go_o === 1'b1) begin
      op_q.push_back(rf_op_o);
      last_rate <= rf_rate_o;
      last_pcnt <= rf_param_cnt_o;
    end
    if (rf_abort_o === 1'b1) aborts++;
    if ((resp_valid_o && resp_ready_i) === 1'b1) begin
      if (exp_q.size() == 0) chk("extra byte", {24'h0, resp_data_o}, 32'hFFFF);
      else chk("resp byte", {23'h0, resp_last_o, resp_data_o}, {23'h0, exp_q.pop_front()});
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_sim();
  end
  initial begin
    logic [31:0] q;
    ptd_bq_type rsp;
    ptd_bq_type cmd;
    logic [7:0] bsel [4] = '{8'h03, 8'h06, 8'h07, 8'h08};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, PTD_REG_STATUS, 32'h0, q);
    chk("status rst", q, 32'h0);
    wb(1'b0, PTD_REG_RETRY, 32'h0, q);
    chk("retry rst", q, {24'h0, PTD_RETRY_RST});
    wb(1'b0, PTD_REG_ANALOG, 32'h0, q);
    chk("analog rst", q, PTD_ANALOG_RST);
    wb(1'b1, PTD_REG_ANALOG, 32'h0D0C0B0A, q);
    wb(1'b0, PTD_REG_ANALOG, 32'h0, q);
    chk("analog rd", q, 32'h0D0C0B0A);
    chk("analog out", rf_analog_o, 32'h0D0C0B0A);
    sel = 4'h5;
    wb(1'b1, PTD_REG_ANALOG, 32'hFFFFFFFF, q);
    sel = 4'hF;
    wb(1'b0, PTD_REG_ANALOG, 32'h0, q);
    chk("analog lanes", q, 32'h0DFF0BFF);
    wb(1'b1, 8'h0C, 32'hFFFFFFFF, q);
    wb(1'b0, 8'h0C, 32'h0, q);
    chk("unmapped", q, 32'h0);
    run('{8'h4A, 8'h00, 8'h00}, '{PTD_ERR_CODE});
    run('{8'h4A, 8'h02, 8'h00}, '{PTD_ERR_CODE});
    run('{8'h4A, 8'h01, 8'h05}, '{PTD_ERR_CODE});
    run('{8'h4A, 8'h01, 8'h09}, '{PTD_ERR_CODE});
    run('{8'h4A, 8'h01, 8'h01, 8'h00, 8'hFF, 8'hFF, 8'h01, 8'h02}, '{PTD_ERR_CODE});
    run('{8'h4A, 8'h01, 8'h02, 8'h00, 8'hFF, 8'hFF, 8'h01}, '{PTD_ERR_CODE});
    run('{8'h4A, 8'h01, 8'h03}, '{PTD_ERR_CODE});
    run('{8'h4B, 8'h01, 8'h00}, '{PTD_ERR_CODE});
    for (int k = 0; k < 2; k++) begin
      rsp = '{PTD_RESP_CODE, 8'h01, PTD_TARGET_NUM, 8'h12, PTD_POLL_RC};
      for (int i = 1; i < 17; i++) rsp.push_back(8'(8'h20 + i));
      cmd = '{PTD_CMD_CODE, 8'h01, 8'(k + 1), 8'h00, 8'hFF, 8'hFF, 8'h01, k ? 8'h0F : 8'h07};
      run(cmd, rsp);
      chk("poll rate", {30'h0, last_rate}, 32'(k + 1));
      chk("poll pcnt", {27'h0, last_pcnt}, 32'h5);
      chk("param tsn", {24'h0, rf_param_o}, k ? 32'h0000000F : 32'h00000007);
    end
    for (int k = 0; k < 4; k++) begin
      rsp = '{PTD_RESP_CODE, 8'h01, PTD_TARGET_NUM};
      for (int i = 0; i < 12; i++) rsp.push_back(8'(8'h50 + i));
      rsp.push_back(8'h01);
      rsp.push_back(8'h01);
      cmd = '{PTD_CMD_CODE, 8'h01, bsel[k], 8'h00};
      if (k == 3) cmd.push_back(8'h01);
      op_q.delete();
      run(cmd, rsp);
      chk("b rate", {30'h0, last_rate}, 32'(k));
      chk("b anti", {28'h0, op_q[1]}, {28'h0, (k == 3) ? OP_PROB_ANTI : OP_SLOT_ANTI});
    end
    @(posedge clk_i);
    seed = lfsr(seed);
    id <= seed;
    rsp = '{PTD_RESP_CODE, 8'h01, PTD_TARGET_NUM, 8'h04, 8'h00, seed[31:24], seed[23:16]};
    rsp.push_back(seed[15:8]);
    rsp.push_back(seed[7:0]);
    run('{PTD_CMD_CODE, 8'h01, PTD_SEL_TAG, 8'hAA, 8'hBB}, rsp);
    chk("param cnt", {27'h0, last_pcnt}, 32'h0);
    chk("active", {31'h0, target_active_o}, 32'h1);
    wb(1'b0, PTD_REG_STATUS, 32'h0, q);
    chk("status found", q, 32'h3);
    for (int k = 0; k < 2; k++) begin
      collide <= k[0];
      rsp = '{PTD_RESP_CODE, 8'h01, PTD_TARGET_NUM, k ? 8'h00 : 8'h04, 8'h00, 8'h20, 8'h07};
      for (int i = 2; i < 9; i++) rsp.push_back(8'(8'h30 + i));
      rsp.push_back(8'h03);
      rsp.push_back(8'h41);
      rsp.push_back(8'h42);
      op_q.delete();
      run('{PTD_CMD_CODE, 8'h01, PTD_SEL_A}, rsp);
      chk("rats op", {28'h0, op_q[2]}, {28'h0, OP_RATS});
    end
    collide <= 1'b0;
    wb(1'b1, PTD_REG_RETRY, 32'h3, q);
    silent <= 1'b1;
    op_q.delete();
    aborts = 0;
    run('{PTD_CMD_CODE, 8'h01, PTD_SEL_A}, '{PTD_RESP_CODE, 8'h00});
    chk("attempts", 32'(op_q.size()), 32'h3);
    chk("aborts", 32'(aborts), 32'h3);
    chk("probe op", {28'h0, op_q[0]}, {28'h0, OP_SENSE});
    chk("inactive", {31'h0, target_active_o}, 32'h0);
    op_q.delete();
    run('{PTD_CMD_CODE, 8'h01, PTD_SEL_A, 8'h11, 8'h22, 8'h33, 8'h44}, '{PTD_RESP_CODE, 8'h00});
    chk("wake op", {28'h0, op_q[0]}, {28'h0, OP_WAKE_ALL});
    end_sim();
  end
endmodule
